// ==== spisf_pkg.sv ====
`default_nettype none
package spisf_pkg;
    localparam logic [7:0] STATUS_ADDR = 8'hbd;
    localparam logic [7:0] DATA_ADDR   = 8'hc0;
    localparam logic [7:0] MASK_ADDR   = 8'hc1;
    localparam logic [7:0] EVENT_ADDR  = 8'hc2;
    localparam logic [7:0] CTRL_ADDR   = 8'hc3;
    localparam int TDONE_BIT = 7;
    localparam int WRITE_COLLISION_FLAG_BIT  = 6;
    localparam int MODE_FAULT_FLAG_BIT  = 5;
    localparam int OVR_BIT   = 4;
    localparam int RFULL_BIT = 3;
    localparam int BUSY_BIT  = 2;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET   = 8'h00;
    localparam logic [1:0] CTRL_RESET   = 2'h0;
    localparam int CTRL_EN_BIT  = 0;
    localparam int CTRL_MST_BIT = 1;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } spisf_bus_type;

    typedef enum logic [1:0] {
        SPISF_IDLE = 2'b00,
        SPISF_BUSY = 2'b01,
        SPISF_END  = 2'b11
    } spisf_state_type;
endpackage
`default_nettype wire

// ==== spisf_track.sv ====
`default_nettype none
// Turns transfer-in-progress into busy level and one end pulse
module spisf_track (
    input  wire logic CLK,
    input  wire logic RST,
    input  wire logic in_progress,
    input  wire logic end_pulse,
    output logic      busy,
    output logic      done
);
    spisf_pkg::spisf_state_type state_q;
    spisf_pkg::spisf_state_type state_d;

    always_comb begin
        state_d = state_q;
        case (state_q)
            spisf_pkg::SPISF_IDLE: if (in_progress) state_d = spisf_pkg::SPISF_BUSY;
            spisf_pkg::SPISF_BUSY: if (end_pulse) state_d = spisf_pkg::SPISF_END;
            spisf_pkg::SPISF_END:  state_d = in_progress ? spisf_pkg::SPISF_BUSY
                                                         : spisf_pkg::SPISF_IDLE;
            default:               state_d = spisf_pkg::SPISF_IDLE;
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) state_q <= spisf_pkg::SPISF_IDLE;
        else     state_q <= state_d;
    end

    assign busy = in_progress;
    assign done = (state_q == spisf_pkg::SPISF_BUSY) && end_pulse;
endmodule
`default_nettype wire

// ==== spisf_irq.sv ====
`default_nettype none
module spisf_irq (
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic [7:0] events,
    input  wire logic       clr,
    input  wire logic       mask_wr,
    input  wire logic [7:0] mask_wdata,
    input  wire logic       ack_rd,
    output logic      [7:0] mask,
    output logic      [7:0] pend,
    output logic            irq
);
    logic [7:0] mask_q;
    logic [7:0] pend_q;
    logic [7:0] pend_d;

    // A new event beats a read clear in the same cycle
    assign pend_d = (ack_rd ? 8'h00 : pend_q) | events;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mask_q <= spisf_pkg::MASK_RESET;
            pend_q <= 8'h00;
        end else begin
            if (mask_wr) mask_q <= mask_wdata;
            pend_q <= clr ? 8'h00 : pend_d;
        end
    end

    assign mask = mask_q;
    assign pend = pend_q;
    assign irq  = |(pend_q & mask_q);
endmodule
`default_nettype wire

// ==== spisf_top.sv ====
`default_nettype none
// Notes on behaviour
// - Transfer-complete flag, bit 7, reset 0, set when a transfer ends.
// - Transfer-complete clears on interrupt vector or on software writing zero.
// - Write-collision flag, bit 6, set by data write while busy.
// - Write-collision clears on written zero or data write while idle.
// - Mode-fault, bit 5, set when master, detection on, select pin low.
// - Mode-fault setting clears peripheral enable and master select.
// - Overrun set at transfer end with receive-full set; cleared by zero or data read.
// - Receive-full set at transfer end; cleared by zero or data read.
// - Busy bit is read-only and follows transfer-in-progress.
// - One data register serves both transmit and receive.
module spisf_top (
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    input  wire logic       XFER_ACTIVE,
    input  wire logic       XFER_END,
    input  wire logic [7:0] RX_BYTE,
    input  wire logic       SEL_PIN,
    input  wire logic       SEL_DETECT_DISABLE,
    input  wire logic       VECTOR_ACK,
    output logic [7:0]      TX_BYTE,
    output logic            TX_LOAD,
    output logic            PERIPH_ENABLE,
    output logic            MASTER_SELECT,
    output logic            SPI_IRQ,
    output logic            EVENT_IRQ
);
    spisf_pkg::spisf_bus_type bus;
    logic       busy;
    logic       done;
    logic [7:0] ev_mask;
    logic [7:0] ev_pend;
    logic [7:0] data_q;
    logic [7:0] rdata_q;
    logic       tdone_q;
    logic       write_collision_flag_q;
    logic       mode_fault_flag_q;
    logic       ovr_q;
    logic       rfull_q;
    logic [1:0] ctrl_q;
    logic       tdone_d;
    logic       write_collision_flag_d;
    logic       mode_fault_flag_d;
    logic       ovr_d;
    logic       rfull_d;
    logic [1:0] ctrl_d;

    assign bus = '{wr: WR, rd: RD, addr: ADDR, wdata: WDATA};

    spisf_track u_track (
        .CLK         (CLK),
        .RST         (RST),
        .in_progress (XFER_ACTIVE),
        .end_pulse   (XFER_END),
        .busy        (busy),
        .done        (done)
    );

    wire status_wr = bus.wr && (bus.addr == spisf_pkg::STATUS_ADDR);
    wire data_wr   = bus.wr && (bus.addr == spisf_pkg::DATA_ADDR);
    wire data_rd   = bus.rd && (bus.addr == spisf_pkg::DATA_ADDR);
    wire mask_wr   = bus.wr && (bus.addr == spisf_pkg::MASK_ADDR);
    wire ctrl_wr   = bus.wr && (bus.addr == spisf_pkg::CTRL_ADDR);
    wire event_rd  = bus.rd && (bus.addr == spisf_pkg::EVENT_ADDR);
    wire zero_tdone = status_wr && !bus.wdata[spisf_pkg::TDONE_BIT];
    wire zero_write_collision_flag  = status_wr && !bus.wdata[spisf_pkg::WRITE_COLLISION_FLAG_BIT];
    wire zero_mode_fault_flag  = status_wr && !bus.wdata[spisf_pkg::MODE_FAULT_FLAG_BIT];
    wire zero_ovr   = status_wr && !bus.wdata[spisf_pkg::OVR_BIT];
    wire zero_rfull = status_wr && !bus.wdata[spisf_pkg::RFULL_BIT];
    wire coll_set  = data_wr && busy;
    wire coll_clr  = zero_write_collision_flag || (data_wr && !busy);
    // Fault only counts while master with detection enabled
    wire fault_set = !SEL_DETECT_DISABLE && ctrl_q[spisf_pkg::CTRL_MST_BIT] && !SEL_PIN;
    wire ovr_set   = done && rfull_q;

    // Every flag: hardware set wins over the clear in the same cycle
    assign tdone_d = done || (tdone_q && !(VECTOR_ACK || zero_tdone));
    assign write_collision_flag_d  = coll_set || (write_collision_flag_q && !coll_clr);
    assign mode_fault_flag_d  = fault_set || (mode_fault_flag_q && !zero_mode_fault_flag);
    assign ovr_d   = ovr_set || (ovr_q && !(zero_ovr || data_rd));
    assign rfull_d = done || (rfull_q && !(zero_rfull || data_rd));
    assign ctrl_d  = fault_set ? 2'h0 : (ctrl_wr ? bus.wdata[1:0] : ctrl_q);

    wire [7:0] status_word = {tdone_q, write_collision_flag_q, mode_fault_flag_q, ovr_q, rfull_q, busy, 2'b00};
    wire [7:0] events = {done, coll_set, fault_set, ovr_set, done, 3'b000};

    // Read mux, unmapped addresses answer zero
    wire [7:0] rd_mux =
        (bus.addr == spisf_pkg::STATUS_ADDR) ? status_word :
        (bus.addr == spisf_pkg::DATA_ADDR)   ? data_q :
        (bus.addr == spisf_pkg::MASK_ADDR)   ? ev_mask :
        (bus.addr == spisf_pkg::EVENT_ADDR)  ? ev_pend :
        (bus.addr == spisf_pkg::CTRL_ADDR)   ? {6'h00, ctrl_q} : 8'h00;

    spisf_irq u_irq (
        .CLK        (CLK),
        .RST        (RST),
        .events     (events),
        .clr        (1'b0),
        .mask_wr    (mask_wr),
        .mask_wdata (bus.wdata),
        .ack_rd     (event_rd),
        .mask       (ev_mask),
        .pend       (ev_pend),
        .irq        (EVENT_IRQ)
    );

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            tdone_q <= 1'b0;
            write_collision_flag_q  <= 1'b0;
            mode_fault_flag_q  <= 1'b0;
            ovr_q   <= 1'b0;
            rfull_q <= 1'b0;
            ctrl_q  <= spisf_pkg::CTRL_RESET;
            data_q  <= 8'h00;
            rdata_q <= 8'h00;
        end else begin
            tdone_q <= tdone_d;
            write_collision_flag_q  <= write_collision_flag_d;
            mode_fault_flag_q  <= mode_fault_flag_d;
            ovr_q   <= ovr_d;
            rfull_q <= rfull_d;
            ctrl_q  <= ctrl_d;
            rdata_q <= bus.rd ? rd_mux : 8'h00;
            // Shared buffer; a received byte replaces the transmit byte
            if (done) data_q <= RX_BYTE;
            else if (data_wr && !busy) data_q <= bus.wdata;
        end
    end

    assign RDATA         = rdata_q;
    assign TX_BYTE       = data_q;
    assign TX_LOAD       = data_wr && !busy;
    assign PERIPH_ENABLE = ctrl_q[spisf_pkg::CTRL_EN_BIT];
    assign MASTER_SELECT = ctrl_q[spisf_pkg::CTRL_MST_BIT];
    assign SPI_IRQ       = tdone_q || write_collision_flag_q || mode_fault_flag_q;
endmodule
`default_nettype wire

// ==== spisf_top_sva.sv ====
`default_nettype none
module spisf_chk (
    input wire logic       CLK,
    input wire logic       RST,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    input wire logic       XFER_ACTIVE,
    input wire logic       XFER_END,
    input wire logic       SEL_PIN,
    input wire logic       SEL_DETECT_DISABLE,
    input wire logic [7:0] TX_BYTE,
    input wire logic       TX_LOAD,
    input wire logic       PERIPH_ENABLE,
    input wire logic       MASTER_SELECT,
    input wire logic       SPI_IRQ
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    wire logic dwr = WR && ADDR == spisf_pkg::DATA_ADDR;
    wire logic srd = RD && ADDR == spisf_pkg::STATUS_ADDR;
    sequence s_end;
        XFER_ACTIVE ##1 XFER_ACTIVE && XFER_END;
    endsequence
    sequence s_fault;
        MASTER_SELECT && !SEL_PIN && !SEL_DETECT_DISABLE;
    endsequence
    a_done_sets: assert property (s_end |=> SPI_IRQ)
        else $error("done flag missing");
    a_fault_irq: assert property (s_fault |=> SPI_IRQ)
        else $error("fault flag missing");
    // Two cycles allowed, though the clear follows the pin and lands one cycle after s_fault, on the edge that sets the flag
    a_fault_stops: assert property (s_fault |-> ##[1:2] !PERIPH_ENABLE && !MASTER_SELECT)
        else $error("control kept on fault");
    a_coll_irq: assert property (dwr && XFER_ACTIVE |=> SPI_IRQ)
        else $error("collision flag missing");
    a_load_idle: assert property (TX_LOAD |-> dwr && !XFER_ACTIVE)
        else $error("load while busy");
    a_tx_kept: assert property (TX_LOAD |=> TX_BYTE == $past(WDATA))
        else $error("data byte wrong");
    a_busy_read: assert property (srd |=> RDATA[2:0] == {$past(XFER_ACTIVE), 2'h0})
        else $error("busy bit wrong");
    a_read_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data outside slot");
endmodule
`default_nettype wire

// ==== spisf_peer.sv ====
`default_nettype none
// Peer clocks one frame of len cycles per load; line carries noise between frames
module spisf_peer (
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic       start,
    input  wire logic [3:0] len,
    input  wire logic [7:0] reply,
    output logic            active,
    output logic            last,
    output logic      [7:0] rx
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_q;
    logic [7:0] noise_q;
    assign active = cnt_q != 4'h0;
    assign last   = cnt_q == 4'h1;
    assign rx     = last ? reply : noise_q;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cnt_q   <= 4'h0;
            noise_q <= 8'h00;
        end else begin
            noise_q <= ~noise_q;
            cnt_q   <= start ? len : cnt_q - {3'h0, active};
        end
    end
endmodule
`default_nettype wire

// ==== spi_status_flags_tb.sv ====
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; \
    $display("BAD %0t got %0h want %0h", $time, (a), (e)); end end
module spi_status_flags_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] ST = spisf_pkg::STATUS_ADDR;
    localparam logic [7:0] DT = spisf_pkg::DATA_ADDR;
    logic       CLK = 0, RST = 1, WR = 0, RD = 0, VECTOR_ACK = 0, SEL_PIN = 1;
    logic       SEL_DETECT_DISABLE = 0, XFER_ACTIVE, XFER_END, TX_LOAD, SPI_IRQ, EVENT_IRQ;
    logic       PERIPH_ENABLE, MASTER_SELECT;
    logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA, RX_BYTE, TX_BYTE;
    logic [3:0] len = 4'h8;
    int         errors = 0, checks = 0;
    spisf_top uut (.CLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .XFER_ACTIVE, .XFER_END, .RX_BYTE,
        .SEL_PIN, .SEL_DETECT_DISABLE, .VECTOR_ACK, .TX_BYTE, .TX_LOAD, .PERIPH_ENABLE,
        .MASTER_SELECT, .SPI_IRQ, .EVENT_IRQ);
    spisf_peer peer (.CLK, .RST, .start(TX_LOAD), .len, .reply(8'h3c), .active(XFER_ACTIVE),
        .last(XFER_END), .rx(RX_BYTE));
    initial forever #5 CLK = ~CLK;
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK) {ADDR, WDATA, WR} <= {a, d, 1'h1};
        @(posedge CLK) WR <= 1'h0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge CLK) {ADDR, RD} <= {a, 1'h1};
        @(posedge CLK) RD <= 1'h0;
        #1 `CHK(RDATA, e)
    endtask
    // Settle first: a load on the edge just passed is not yet visible on the peer
    task wend;
        #1;
        for (int i = 0; i < 20 && XFER_ACTIVE; i++) @(posedge CLK) #1;
        `CHK(XFER_ACTIVE, 1'h0)
        @(posedge CLK) #1;
    endtask
    task t_xfer;
        rd(ST, spisf_pkg::STATUS_RESET);
        rd(8'hc4, 8'h00);
        wr(spisf_pkg::MASK_ADDR, 8'h10);
        wr(DT, 8'h5a);
        rd(ST, 8'h04);
        wr(DT, 8'h11);
        wend;
        `CHK(TX_BYTE, 8'h3c)
        rd(ST, 8'hc8);
        `CHK(SPI_IRQ, 1'h1)
        rd(DT, 8'h3c);
        rd(ST, 8'hc0);
        @(posedge CLK) VECTOR_ACK <= 1'h1;
        @(posedge CLK) {VECTOR_ACK, len} <= {1'h0, 4'h3};
        rd(ST, 8'h40);
        wr(DT, 8'h22);
        rd(ST, 8'h04);
        wend;
        rd(ST, 8'h88);
        wr(DT, 8'h33);
        wend;
        rd(ST, 8'h98);
        `CHK(EVENT_IRQ, 1'h1)
        rd(DT, 8'h3c);
        rd(ST, 8'h80);
        rd(spisf_pkg::EVENT_ADDR, 8'hd8);
        `CHK(EVENT_IRQ, 1'h0)
        wr(ST, 8'h00);
        rd(ST, 8'h00);
        `CHK(SPI_IRQ, 1'h0)
    endtask
    task t_fault;
        wr(spisf_pkg::CTRL_ADDR, 8'h03);
        @(posedge CLK) {SEL_DETECT_DISABLE, SEL_PIN} <= 2'h2;
        rd(ST, 8'h00);
        @(posedge CLK) SEL_DETECT_DISABLE <= 1'h0;
        rd(ST, 8'h20);
        rd(spisf_pkg::CTRL_ADDR, 8'h00);
        `CHK(SPI_IRQ, 1'h1)
        @(posedge CLK) SEL_PIN <= 1'h1;
        wr(ST, 8'h00);
        rd(ST, 8'h00);
    endtask
    task results;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge CLK);
        RST <= 1'h0;
        t_xfer;
        t_fault;
        results;
    end
    // Whole run is under a hundred cycles; this only catches a hang
    initial begin
        #20000;
        errors++;
        results;
    end
endmodule
bind spisf_top spisf_chk u_chk (.CLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .XFER_ACTIVE,
    .XFER_END, .SEL_PIN, .SEL_DETECT_DISABLE, .TX_BYTE, .TX_LOAD, .PERIPH_ENABLE,
    .MASTER_SELECT, .SPI_IRQ);
`default_nettype wire
